//--- common/cpr_defines.svh
`ifndef CPR_DEFINES_SVH
`define CPR_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CPR_ADDR_OV_ALARM 8'h07
`define CPR_ADDR_CUR_LIMIT 8'h08
`define CPR_ADDR_CUR_ALARM 8'h09
`define CPR_ADDR_FAULT 8'h0A
`define CPR_ADDR_CHG_MAIN 8'h0B
`define CPR_ADDR_CHG_AUX 8'h0C
// ----------------------------------------
// reset values
// ----------------------------------------
`define CPR_OV_LEVEL_RST 7'h38
`define CPR_OC_PROT_RST 4'hD
`define CPR_OC_ALARM_RST 7'h50
`define CPR_FREQ_RST 2'h2
`define CPR_WD_PER_RST 2'h0
`define CPR_ROLE_SLAVE 2'h1
// ----------------------------------------
// field positions
// ----------------------------------------
`define CPR_BIT_OFF 7
`define CPR_BIT_RISE_EVT 6
`define CPR_BIT_RISE_MASK 5
`define CPR_BIT_FALL_EVT 4
`define CPR_BIT_WD_EVT 3
`define CPR_BIT_WD_OFF 2
// ----------------------------------------
// timing
// ----------------------------------------
`define CPR_CLK_HZ 40000000
`define CPR_WD_MS_0 500
`define CPR_WD_MS_1 1000
`define CPR_WD_MS_2 5000
`define CPR_WD_MS_3 30000
`define CPR_WD_CYC(ms) ((ms) * (`CPR_CLK_HZ / 1000))
`define CPR_RAMP_TIMEOUT_CYC 4000
`endif

//--- common/cpr_pkg.sv
package cpr_pkg;
  typedef logic [7:0] cpr_byte_t;
  typedef enum logic [2:0] {
    CPR_TO_IDLE = 3'b001,
    CPR_TO_WAIT = 3'b010,
    CPR_TO_DONE = 3'b100
  } cpr_to_state_e;
endpackage

//--- src/cpr_event_flag.sv
`timescale 1ns/100ps
// sticky event flag: set on rising edge of source, clear on read, set wins
module cpr_event_flag (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic cond_in,
  input wire logic clear_in,
  output logic flag_out,
  output logic rise_out
);
  logic cond_q;
  logic flag_q;
  wire rise_w = cond_in & ~cond_q;
  assign flag_out = flag_q;
  assign rise_out = rise_w;
  // edge memory and flag
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      cond_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      cond_q <= cond_in;
      if (rise_w) begin
        flag_q <= 1'b1;
      end else if (clear_in) begin
        flag_q <= 1'b0;
      end
    end
  end
endmodule // cpr_event_flag

//--- src/cpr_watchdog.sv
`timescale 1ns/100ps
`include "cpr_defines.svh"
// watchdog counter with selectable period, restarted on host access
module cpr_watchdog #(
  parameter int unsigned CNT_W = 32,
  parameter logic [31:0] PER0 = 32'(`CPR_WD_CYC(`CPR_WD_MS_0)),
  parameter logic [31:0] PER1 = 32'(`CPR_WD_CYC(`CPR_WD_MS_1)),
  parameter logic [31:0] PER2 = 32'(`CPR_WD_CYC(`CPR_WD_MS_2)),
  parameter logic [31:0] PER3 = 32'(`CPR_WD_CYC(`CPR_WD_MS_3))
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic enable_in,
  input wire logic kick_in,
  input wire logic [1:0] period_sel_in,
  output logic expire_out
);
  logic [31:0] cnt_q;
  logic [31:0] limit_w;
  assign limit_w = (period_sel_in == 2'h0) ? PER0 :
                   (period_sel_in == 2'h1) ? PER1 :
                   (period_sel_in == 2'h2) ? PER2 : PER3;
  assign expire_out = enable_in & (cnt_q >= limit_w - 32'h1);
  // count while enabled, restart on access or expiry
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      cnt_q <= 32'h0;
    end else if (!enable_in || kick_in || expire_out) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
  initial begin
    if (CNT_W != 32 || PER0 == 0 || PER1 == 0 || PER2 == 0 || PER3 == 0) begin
      $error("watchdog periods must be nonzero and counter 32 bits");
    end
  end
endmodule // cpr_watchdog

//--- src/cpr_reg_bank.sv
`timescale 1ns/100ps
`include "cpr_defines.svh"
// Function
// [R1] bus over-voltage alarm off bit: 0 enables; resets 1 in slave role.
// [R2] 7-bit over-voltage alarm level, 6V+n*50mV, reset 0111000.
// [R3] 4-bit over-current protect level reset 1101; bit 7 turns it off.
// [R4] current rise sets sticky event and interrupts; read clears it.
// [R5] rise mask bit 1 blocks rise interrupt; resets to 0.
// [R6] current fall sets sticky event and interrupts; read clears it.
// [R7] 7-bit over-current alarm level n*50mA, reset 1010000; bit 7 turns off.
// [R8] die over-temperature sets sticky event and interrupts; read clears it.
// [R9] live die-hot bit mirrors the present condition.
// [R10] bus-volt-low live bit, evaluated only before switching.
// [R11] bus-volt-high live bit, evaluated only before switching.
// [R12] no current rise within timeout after charge enable sets timeout event.
// [R13] switching live bit; switching start starts timer, one interrupt.
// [R14] converter over-current sets sticky event and interrupts; read clears.
// [R15] flying-capacitor short in soft-start sets sticky event; read clears.
// [R16] writing 1 to register-reset bit restores reset-affected fields.
// [R17] 2-bit frequency select, reset 10, untouched by register reset.
// [R18] watchdog expiry sets sticky event and interrupts; read clears.
// [R19] watchdog runs when off bit 0; period 0.5s,1s,5s,30s.
// [R20] charge enable clears on watchdog expiry and register reset.
// [R21] read-only role field: 00 standalone, 01 slave, 1X master.
// [R22] interrupt on any unmasked flag rising; read clears only flags then set.
// [R23] watchdog restarts on host access; ramp timeout length is a parameter.
module cpr_reg_bank
  import cpr_pkg::*;
#(
  parameter int unsigned RAMP_TIMEOUT_CYC = `CPR_RAMP_TIMEOUT_CYC,
  parameter logic [31:0] WD_PER0 = 32'(`CPR_WD_CYC(`CPR_WD_MS_0)),
  parameter logic [31:0] WD_PER1 = 32'(`CPR_WD_CYC(`CPR_WD_MS_1)),
  parameter logic [31:0] WD_PER2 = 32'(`CPR_WD_CYC(`CPR_WD_MS_2)),
  parameter logic [31:0] WD_PER3 = 32'(`CPR_WD_CYC(`CPR_WD_MS_3))
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [1:0] role_select_in,
  input wire logic cur_rise_in,
  input wire logic cur_fall_in,
  input wire logic die_hot_in,
  input wire logic volt_low_in,
  input wire logic volt_high_in,
  input wire logic switching_in,
  input wire logic conv_oc_in,
  input wire logic cap_short_in,
  output logic irq_out,
  output logic bus_ov_alarm_off_out,
  output logic [6:0] bus_ov_alarm_level_out,
  output logic bus_oc_protect_off_out,
  output logic [3:0] bus_oc_protect_level_out,
  output logic bus_oc_alarm_off_out,
  output logic [6:0] bus_oc_alarm_level_out,
  output logic [1:0] switch_freq_select_out,
  output logic charge_enable_out
);
  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic bus_ov_alarm_off_q;
  logic [6:0] bus_ov_alarm_level_q;
  logic bus_oc_protect_off_q;
  logic [3:0] bus_oc_protect_level_q;
  logic undercurrent_rise_irq_mask_q;
  logic bus_oc_alarm_off_q;
  logic [6:0] bus_oc_alarm_level_q;
  logic [1:0] switch_freq_select_q;
  logic watchdog_off_q;
  logic [1:0] watchdog_period_select_q;
  logic charge_enable_q;
  logic [1:0] role_q;
  logic [7:0] rdata_q;
  logic irq_q;
  logic volt_low_q;
  logic volt_high_q;
  logic die_hot_q;
  logic switching_q;
  cpr_to_state_e to_state_q;
  cpr_to_state_e to_state_d;
  logic [31:0] to_cnt_q;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire sel_07 = (reg_addr_in == `CPR_ADDR_OV_ALARM);
  wire sel_08 = (reg_addr_in == `CPR_ADDR_CUR_LIMIT);
  wire sel_09 = (reg_addr_in == `CPR_ADDR_CUR_ALARM);
  wire sel_0a = (reg_addr_in == `CPR_ADDR_FAULT);
  wire sel_0b = (reg_addr_in == `CPR_ADDR_CHG_MAIN);
  wire sel_0c = (reg_addr_in == `CPR_ADDR_CHG_AUX);
  wire wr_07 = reg_wr_in & sel_07;
  wire wr_08 = reg_wr_in & sel_08;
  wire wr_09 = reg_wr_in & sel_09;
  wire wr_0b = reg_wr_in & sel_0b;
  wire wr_0c = reg_wr_in & sel_0c;
  wire rd_08 = reg_rd_in & sel_08;
  wire rd_0a = reg_rd_in & sel_0a;
  wire rd_0b = reg_rd_in & sel_0b;
  wire reg_rst = wr_0b & reg_wdata_in[`CPR_BIT_OFF]; // R16
  wire access = reg_wr_in | reg_rd_in;
  wire is_slave = (role_q == `CPR_ROLE_SLAVE); // R21

  // ----------------------------------------
  // event flags
  // ----------------------------------------
  // order: 0 rise, 1 fall, 2 die hot, 3 timeout, 4 conv oc, 5 cap short, 6 watchdog, 7 switching
  logic [7:0] ev_cond;
  logic [7:0] ev_clr;
  logic [7:0] ev_flag;
  logic [7:0] ev_rise;
  logic timeout_hit;
  logic wd_expire;
  assign ev_cond = {switching_in, wd_expire, cap_short_in, conv_oc_in, timeout_hit, die_hot_in,
                    cur_fall_in, cur_rise_in};
  assign ev_clr = {1'b0, rd_0b, rd_0a, rd_0a, rd_0a, rd_0a, rd_08, rd_08}; // R22
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_ev
      cpr_event_flag u_flag (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .cond_in(ev_cond[gi]),
        .clear_in(ev_clr[gi] & ev_flag[gi]),
        .flag_out(ev_flag[gi]),
        .rise_out(ev_rise[gi])
      );
    end
  endgenerate
  // unmasked rising events feed the interrupt pulse
  wire [7:0] ev_irq = ev_rise & {7'h7F, ~undercurrent_rise_irq_mask_q}; // R4 R5 R6 R8 R14 R15 R18 R13

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  cpr_watchdog #(
    .CNT_W(32),
    .PER0(WD_PER0),
    .PER1(WD_PER1),
    .PER2(WD_PER2),
    .PER3(WD_PER3)
  ) u_wd (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .enable_in(~watchdog_off_q), // R19
    .kick_in(access), // R23
    .period_sel_in(watchdog_period_select_q),
    .expire_out(wd_expire)
  );

  // ----------------------------------------
  // ramp timeout state machine
  // ----------------------------------------
  wire sw_start = switching_in & ~switching_q;
  always_comb begin
    to_state_d = to_state_q;
    case (to_state_q)
      CPR_TO_IDLE: if (sw_start && charge_enable_q) to_state_d = CPR_TO_WAIT; // R13
      CPR_TO_WAIT: begin
        if (!charge_enable_q || cur_rise_in) to_state_d = CPR_TO_IDLE;
        else if (to_cnt_q >= RAMP_TIMEOUT_CYC - 1) to_state_d = CPR_TO_DONE; // R12
      end
      CPR_TO_DONE: if (!charge_enable_q) to_state_d = CPR_TO_IDLE;
      default: to_state_d = CPR_TO_IDLE;
    endcase
  end
  assign timeout_hit = (to_state_q == CPR_TO_DONE); // R12

  // timer and state
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      to_state_q <= CPR_TO_IDLE;
      to_cnt_q <= 32'h0;
      switching_q <= 1'b0;
    end else begin
      to_state_q <= to_state_d;
      to_cnt_q <= (to_state_q == CPR_TO_WAIT) ? to_cnt_q + 32'h1 : 32'h0;
      switching_q <= switching_in;
    end
  end

  // ----------------------------------------
  // live status
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      die_hot_q <= 1'b0;
      volt_low_q <= 1'b0;
      volt_high_q <= 1'b0;
    end else begin
      die_hot_q <= die_hot_in; // R9
      volt_low_q <= switching_in ? 1'b0 : volt_low_in; // R10
      volt_high_q <= switching_in ? 1'b0 : volt_high_in; // R11
    end
  end

  // ----------------------------------------
  // role capture after reset release
  // ----------------------------------------
  logic role_valid_q;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      role_q <= 2'h0;
      role_valid_q <= 1'b0;
    end else if (!role_valid_q) begin
      role_q <= role_select_in; // R21
      role_valid_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  wire cfg_rst = !role_valid_q || reg_rst;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      bus_ov_alarm_off_q <= 1'b0;
      bus_ov_alarm_level_q <= `CPR_OV_LEVEL_RST;
      bus_oc_protect_off_q <= 1'b0;
      bus_oc_protect_level_q <= `CPR_OC_PROT_RST;
      undercurrent_rise_irq_mask_q <= 1'b0;
      bus_oc_alarm_off_q <= 1'b0;
      bus_oc_alarm_level_q <= `CPR_OC_ALARM_RST;
      watchdog_off_q <= 1'b0;
      watchdog_period_select_q <= `CPR_WD_PER_RST;
    end else if (cfg_rst) begin
      bus_ov_alarm_off_q <= role_valid_q ? is_slave : (role_select_in == `CPR_ROLE_SLAVE); // R1
      bus_ov_alarm_level_q <= `CPR_OV_LEVEL_RST; // R2
      bus_oc_protect_off_q <= 1'b0;
      bus_oc_protect_level_q <= `CPR_OC_PROT_RST; // R3
      undercurrent_rise_irq_mask_q <= 1'b0;
      bus_oc_alarm_off_q <= 1'b0;
      bus_oc_alarm_level_q <= `CPR_OC_ALARM_RST; // R7
      watchdog_off_q <= 1'b0;
      watchdog_period_select_q <= `CPR_WD_PER_RST;
    end else begin
      if (wr_07) begin
        bus_ov_alarm_off_q <= reg_wdata_in[`CPR_BIT_OFF]; // R1
        bus_ov_alarm_level_q <= reg_wdata_in[6:0]; // R2
      end
      if (wr_08) begin
        bus_oc_protect_off_q <= reg_wdata_in[`CPR_BIT_OFF]; // R3
        undercurrent_rise_irq_mask_q <= reg_wdata_in[`CPR_BIT_RISE_MASK]; // R5
        bus_oc_protect_level_q <= reg_wdata_in[3:0];
      end
      if (wr_09) begin
        bus_oc_alarm_off_q <= reg_wdata_in[`CPR_BIT_OFF]; // R7
        bus_oc_alarm_level_q <= reg_wdata_in[6:0];
      end
      if (wr_0b) begin
        watchdog_off_q <= reg_wdata_in[`CPR_BIT_WD_OFF]; // R19
        watchdog_period_select_q <= reg_wdata_in[1:0];
      end
    end
  end

  // frequency select survives register reset; charge enable does not
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      switch_freq_select_q <= `CPR_FREQ_RST;
      charge_enable_q <= 1'b0;
    end else begin
      if (wr_0b) switch_freq_select_q <= reg_wdata_in[6:5]; // R17
      if (reg_rst || wd_expire) charge_enable_q <= 1'b0; // R20
      else if (wr_0c) charge_enable_q <= reg_wdata_in[`CPR_BIT_OFF];
    end
  end

  // ----------------------------------------
  // read mux and interrupt
  // ----------------------------------------
  wire [7:0] rd_mux =
    sel_07 ? {bus_ov_alarm_off_q, bus_ov_alarm_level_q} :
    sel_08 ? {bus_oc_protect_off_q, ev_flag[0], undercurrent_rise_irq_mask_q, ev_flag[1],
              bus_oc_protect_level_q} :
    sel_09 ? {bus_oc_alarm_off_q, bus_oc_alarm_level_q} :
    sel_0a ? {ev_flag[2], die_hot_q, volt_low_q, volt_high_q, ev_flag[3], switching_q,
              ev_flag[4], ev_flag[5]} :
    sel_0b ? {1'b0, switch_freq_select_q, 1'b0, ev_flag[6], watchdog_off_q, watchdog_period_select_q} :
    sel_0c ? {charge_enable_q, role_q, 5'h00} : 8'h00;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      if (reg_rd_in) rdata_q <= rd_mux;
      irq_q <= |ev_irq; // R22
    end
  end

  assign reg_rdata_out = rdata_q;
  assign irq_out = irq_q;
  assign bus_ov_alarm_off_out = bus_ov_alarm_off_q;
  assign bus_ov_alarm_level_out = bus_ov_alarm_level_q;
  assign bus_oc_protect_off_out = bus_oc_protect_off_q;
  assign bus_oc_protect_level_out = bus_oc_protect_level_q;
  assign bus_oc_alarm_off_out = bus_oc_alarm_off_q;
  assign bus_oc_alarm_level_out = bus_oc_alarm_level_q;
  assign switch_freq_select_out = switch_freq_select_q;
  assign charge_enable_out = charge_enable_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  initial begin
    if (RAMP_TIMEOUT_CYC < 2) $error("ramp timeout too short");
  end

  rise_flag_set_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R4
    $rose(cur_rise_in) |=> ev_flag[0]) else $error("rise event not captured");
  rise_mask_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R5
    ($rose(cur_rise_in) && undercurrent_rise_irq_mask_q && !(|ev_irq[7:1])) |=> !irq_q)
    else $error("masked rise raised interrupt");
  fall_flag_set_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R6
    $rose(cur_fall_in) |=> ev_flag[1]) else $error("fall event not captured");
  die_flag_set_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R8
    $rose(die_hot_in) |=> ev_flag[2] && irq_q) else $error("die hot not flagged");
  die_live_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R9
    1'b1 |=> die_hot_q == $past(die_hot_in)) else $error("die live bit wrong");
  volt_gate_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R10
    switching_in |=> !volt_low_q && !volt_high_q) else $error("volt status while switching");
  sw_irq_once_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R13
    $rose(switching_in) ##1 switching_in [*2] |-> !ev_rise[7]) else $error("switching irq repeated");
  conv_oc_set_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R14
    $rose(conv_oc_in) |=> ev_flag[4]) else $error("converter oc not flagged");
  cap_short_set_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R15
    $rose(cap_short_in) |=> ev_flag[5]) else $error("cap short not flagged");
  reg_rst_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R16
    reg_rst |=> bus_ov_alarm_level_q == `CPR_OV_LEVEL_RST && !charge_enable_q)
    else $error("register reset incomplete");
  freq_keep_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R17
    !wr_0b |=> $stable(switch_freq_select_q)) else $error("frequency changed");
  wd_charge_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R20
    wd_expire |=> !charge_enable_q && ev_flag[6]) else $error("watchdog expiry ignored");
  read_clear_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R22
    (rd_0a && ev_flag[4] && !ev_rise[4]) |=> !ev_flag[4]) else $error("read did not clear");
endmodule // cpr_reg_bank

//--- dv/cpr_analog_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// analog front end stand-in
// ----------------------------------------
// comparator levels follow the bench request at the next rising edge
module cpr_analog_model (
  input wire logic core_clk_in,
  input wire logic [7:0] cond_req_in,
  output logic [7:0] cond_out
);
  // levels start quiet so no event is seen at power-up
  initial begin
    cond_out = 8'h00;
  end
  // each level holds until the bench asks for another; taken on the rising edge so the
  // bench's falling-edge request never races the model
  always @(posedge core_clk_in) begin
    cond_out <= cond_req_in;
  end
endmodule // cpr_analog_model

//--- dv/tb_charger_protection_register_bank.sv
`timescale 1ns/100ps
module tb_charger_protection_register_bank;
  import cpr_pkg::*;
  logic core_clk_in, resetn_in, reg_wr_in, reg_rd_in, irq_out, rd_taken;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, cond_req, cond;
  logic [1:0] role_select_in, freq, lf;
  logic ov_off, ocp_off, oca_off, charge_enable;
  logic [6:0] ov_lvl, oca_lvl;
  logic [3:0] ocp_lvl;
  cpr_byte_t w;
  cpr_byte_t exp_q[$];
  cpr_byte_t ev_c[4] = '{8'h01, 8'h02, 8'h40, 8'h80};
  cpr_byte_t ev_a[4] = '{8'h08, 8'h08, 8'h0A, 8'h0A};
  cpr_byte_t ev_e[4] = '{8'h4D, 8'h1D, 8'h02, 8'h01};
  cpr_byte_t ev_b[4] = '{8'h0D, 8'h0D, 8'h00, 8'h00};
  int bad_count, samples_checked, irq_cnt, seed, i, n;
  // ----------------------------------------
  // clock, design and analog model
  // ----------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  cpr_reg_bank #(.RAMP_TIMEOUT_CYC(10), .WD_PER0(32'h64), .WD_PER1(32'hC8), .WD_PER2(32'h12C),
    .WD_PER3(32'h190)) dut (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .role_select_in(role_select_in), .cur_rise_in(cond[0]), .cur_fall_in(cond[1]), .die_hot_in(cond[2]),
    .volt_low_in(cond[3]), .volt_high_in(cond[4]), .switching_in(cond[5]), .conv_oc_in(cond[6]),
    .cap_short_in(cond[7]), .irq_out(irq_out), .bus_ov_alarm_off_out(ov_off), .bus_ov_alarm_level_out(ov_lvl),
    .bus_oc_protect_off_out(ocp_off), .bus_oc_protect_level_out(ocp_lvl), .bus_oc_alarm_off_out(oca_off),
    .bus_oc_alarm_level_out(oca_lvl), .switch_freq_select_out(freq), .charge_enable_out(charge_enable));
  cpr_analog_model afe (.core_clk_in(core_clk_in), .cond_req_in(cond_req), .cond_out(cond));
  // ----------------------------------------
  // compare, bus and closing tasks
  // ----------------------------------------
  task automatic check_level(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_rdata(input logic [7:0] got);
    check_level(got, exp_q.pop_front());
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
    // one quiet cycle so a following call never re-drives the strobe in this step
    @(negedge core_clk_in);
  endtask
  // read data is noted now and compared by the monitor one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge core_clk_in);
    reg_rd_in = 1'b0;
    @(negedge core_clk_in);
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge core_clk_in);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // monitors and hang guard
  // ----------------------------------------
  // a read taken at a rising edge shows its data by the next falling edge
  always @(posedge core_clk_in) begin
    rd_taken <= reg_rd_in;
    if (irq_out === 1'b1) irq_cnt++;
  end
  always @(negedge core_clk_in) begin
    if (rd_taken === 1'b1) check_rdata(reg_rdata_out);
  end
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 788;
    rd_taken = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    cond_req = 8'h00;
    role_select_in = 2'h0;
    resetn_in = 1'b0;
    idle(4);
    resetn_in = 1'b1;
    idle(2);
    // reset values, unmapped place
    check_level({ov_off, ov_lvl}, 8'h38);
    check_level({ocp_off, 3'h0, ocp_lvl}, 8'h0D);
    check_level({oca_off, oca_lvl}, 8'h50);
    check_level({6'h00, freq}, 8'h02);
    rd(8'h07, 8'h38);
    rd(8'h08, 8'h0D);
    rd(8'h09, 8'h50);
    rd(8'h0A, 8'h00);
    rd(8'h0B, 8'h40);
    rd(8'h0C, 8'h00);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    $display("reset values test done");
    // random writes, read-only bits kept
    for (i = 0; i < 8; i++) begin
      w = 8'($random(seed));
      wr(8'h07, w);
      wr(8'h09, ~w);
      wr(8'h08, w);
      wr(8'h0B, w & 8'h7F);
      wr(8'h0A, w);
      wr(8'h0C, w);
      lf = w[6:5];
      rd(8'h07, w);
      rd(8'h09, ~w);
      rd(8'h08, w & 8'hAF);
      rd(8'h0B, w & 8'h67);
      rd(8'h0A, 8'h00);
      rd(8'h0C, w & 8'h80);
      check_level({ov_off, ov_lvl}, w);
      check_level({ocp_off, 3'h0, ocp_lvl}, w & 8'h8F);
      check_level({oca_off, oca_lvl}, ~w);
      check_level({6'h00, freq}, {6'h00, lf});
    end
    wr(8'h0B, {1'b1, lf, 5'h00});
    check_level({7'h00, charge_enable}, 8'h00);
    check_level({6'h00, freq}, {6'h00, lf});
    rd(8'h07, 8'h38);
    rd(8'h0B, {1'b0, lf, 5'h00});
    $display("write read test done");
    // sticky events, one interrupt each unless masked, cleared by read
    for (i = 0; i < 4; i++) begin
      n = irq_cnt;
      cond_req = ev_c[i];
      idle(4);
      cond_req = 8'h00;
      check_level(8'(irq_cnt - n), 8'h01);
      rd(ev_a[i], ev_e[i]);
      rd(ev_a[i], ev_b[i]);
      idle(2);
    end
    cond_req = 8'h04;
    idle(4);
    rd(8'h0A, 8'hC0);
    rd(8'h0A, 8'h40);
    cond_req = 8'h00;
    idle(3);
    rd(8'h0A, 8'h00);
    wr(8'h08, 8'h2D);
    n = irq_cnt;
    cond_req = 8'h01;
    idle(4);
    cond_req = 8'h00;
    check_level(8'(irq_cnt - n), 8'h00);
    rd(8'h08, 8'h6D);
    cond_req = 8'h18;
    idle(3);
    rd(8'h0A, 8'h30);
    cond_req = 8'h00;
    idle(3);
    rd(8'h0A, 8'h00);
    $display("event test done");
    // switching start and current ramp timeout
    wr(8'h0C, 8'h80);
    n = irq_cnt;
    cond_req = 8'h20;
    idle(20);
    check_level(8'(irq_cnt - n), 8'h02);
    rd(8'h0A, 8'h0C);
    rd(8'h0A, 8'h04);
    cond_req = 8'h00;
    idle(3);
    rd(8'h0A, 8'h00);
    $display("ramp timeout test done");
    // watchdog expiry, then watchdog stopped
    n = irq_cnt;
    idle(130);
    check_level(8'(irq_cnt - n), 8'h01);
    check_level({7'h00, charge_enable}, 8'h00);
    rd(8'h0B, {1'b0, lf, 5'h08});
    rd(8'h0B, {1'b0, lf, 5'h00});
    wr(8'h0B, {1'b0, lf, 5'h04});
    n = irq_cnt;
    idle(250);
    check_level(8'(irq_cnt - n), 8'h00);
    rd(8'h0B, {1'b0, lf, 5'h04});
    $display("watchdog test done");
    // second reset in slave role
    resetn_in = 1'b0;
    role_select_in = 2'h1;
    idle(4);
    resetn_in = 1'b1;
    idle(2);
    check_level({7'h00, ov_off}, 8'h01);
    rd(8'h07, 8'hB8);
    rd(8'h0C, 8'h20);
    rd(8'h0B, 8'h40);
    idle(2);
    $display("slave reset test done");
    stop_test();
  end
endmodule // tb_charger_protection_register_bank
